/* File: src/rsc_defs.vh */
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
// ==========================================================
// timing
`define RSC_CLK_HZ 50000000
`define RSC_RST_HOLD_US 500
// 500 us at 50 MHz; written out, as the product overflows 32 bits
`define RSC_RST_HOLD_CYC 16'h61A8
// bootloader request length in clock cycles
`define RSC_BOOT_REQ_CYC 16'h2202
`define RSC_CNT_W 16
// ==========================================================
// io counts and pull codes
`define RSC_NUM_GPIO 11
`define RSC_PULL_UP 2'h1
`define RSC_PULL_DOWN 2'h2
`define RSC_DRIVE 2'h3
// ==========================================================
// states
`define RSC_ST_OFF 3'h0
`define RSC_ST_HOLD 3'h1
`define RSC_ST_FW 3'h2
`define RSC_ST_APP 3'h3
`define RSC_ST_BOOT 3'h4
`endif

/* File: src/rsc_sync.v */
`timescale 1ns/1ns
// ==========================================================
// two flop synchroniser, one per bit
module rsc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  // clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // data
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta;

  // first stage feeds only the second
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      // reset value per bit is the idle level of its pin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

/* File: src/rsc_startup_ctrl.v */
`timescale 1ns/1ns
`include "rsc_defs.vh"
// How it works
// - pins start in weak pull-up, test pull-down
// - firmware may change io drive after startup
// - enable low enters shutdown
// - chip pulls reset low; host never drives high
// - undriven reset pin pulled high internally
// - reset pin low pulse resets fully
// - strap may become strong output after startup
// - ready held low 8706 cycles forces bootloader
// - ready driven low after application startup; code drives it from slave_ready_i in the APP state
// - ready then serves serial handshake
// - interrupt asserted low when data ready; code asserts it only in the APP and BOOT states
// - release reset about 500 us after enable
// - enable low stops serial and io activity
module rsc_startup_ctrl (
  // clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // chip control pins
  input wire enable_i,
  input wire reset_n_i,
  output wire reset_n_o,
  output wire reset_n_oe_o,
  output wire reset_pull_up_o,
  output wire test_pull_down_o,
  // ready line
  input wire ready_n_i,
  output wire ready_n_o,
  output wire ready_n_oe_o,
  output wire ready_pull_up_o,
  // firmware side
  input wire fw_done_i,
  input wire data_ready_i,
  input wire slave_ready_i,
  input wire [`RSC_NUM_GPIO-1:0] fw_io_drive_i,
  input wire [`RSC_NUM_GPIO-1:0] fw_io_out_i,
  input wire fw_strap_drive_i,
  input wire fw_strap_out_i,
  input wire [`RSC_NUM_GPIO-1:0] gpio_i,
  input wire strap_i,
  // io pad control
  output reg [`RSC_NUM_GPIO-1:0] gpio_o,
  output reg [`RSC_NUM_GPIO-1:0] gpio_oe_o,
  output reg [`RSC_NUM_GPIO-1:0] gpio_pull_up_o,
  output reg strap_o,
  output reg strap_oe_o,
  output reg strap_pull_up_o,
  output wire strap_level_o,
  // status
  output wire irq_n_o,
  output wire shutdown_o,
  output wire core_rst_o,
  output wire fw_run_o,
  output reg boot_loader_o,
  output wire serial_en_o
);
  // ==========================================================
  // input synchronisers
  wire [3:0] pins_sync;
  wire en_s;
  wire rst_n_s;
  wire rdy_n_s;
  wire strap_s;

  // pins are from outside the clock domain; reset values match each
  // pin's idle level (enable off, reset and ready released), so no
  // false enable or reset edge follows the end of system reset
  rsc_sync #(.W(4), .RST_VAL(4'h7)) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({enable_i, reset_n_i, ready_n_i, strap_i}),
    .sync_o({en_s, rst_n_s, rdy_n_s, strap_s})
  );
  assign strap_level_o = strap_s;

  // ==========================================================
  // sequencer
  reg [2:0] state;
  reg [2:0] next_state;
  reg [`RSC_CNT_W-1:0] cnt;
  reg [`RSC_CNT_W-1:0] next_cnt;
  reg [`RSC_CNT_W-1:0] low_cnt;
  reg next_boot;
  reg rst_n_d;
  wire hold_done;
  wire boot_req;

  // hold count saturates at its end value, so a host that keeps
  // reset low for a long time never wraps it back into driving
  assign hold_done = (cnt >= `RSC_RST_HOLD_CYC);
  // ready must be low for the last 8706 cycles of hold, unbroken;
  // counted on the system clock, as the block has no second clock
  assign boot_req = (low_cnt >= `RSC_BOOT_REQ_CYC);

  // next state: enable low always wins over every other state
  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_boot = boot_loader_o;
    case (state)
      `RSC_ST_OFF: begin
        next_cnt = {`RSC_CNT_W{1'b0}};
        next_boot = 1'b0;
        if (en_s) begin
          next_state = `RSC_ST_HOLD;
        end
      end
      `RSC_ST_HOLD: begin
        if (!hold_done) begin
          next_cnt = cnt + 1'b1;
        end
        // chip lets go at hold_done; a host still holding reset low
        // keeps the chip here until the pin reads high
        if (hold_done && rst_n_s) begin
          next_state = `RSC_ST_FW;
          next_boot = boot_req;
        end
      end
      `RSC_ST_FW: begin
        if (fw_done_i || boot_loader_o) begin
          next_state = boot_loader_o ? `RSC_ST_BOOT : `RSC_ST_APP;
        end
      end
      `RSC_ST_APP: begin
        next_state = `RSC_ST_APP;
      end
      `RSC_ST_BOOT: begin
        next_state = `RSC_ST_BOOT;
      end
      default: begin
        next_state = `RSC_ST_OFF;
      end
    endcase
    if (!en_s) begin
      next_state = `RSC_ST_OFF;
    end else if (state != `RSC_ST_OFF && state != `RSC_ST_HOLD && rst_n_d && !rst_n_s) begin
      // low edge on reset pin restarts without power cycling
      next_state = `RSC_ST_HOLD;
      next_cnt = {`RSC_CNT_W{1'b0}};
      next_boot = 1'b0;
    end
  end

  // state registers
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= `RSC_ST_OFF;
      cnt <= {`RSC_CNT_W{1'b0}};
      boot_loader_o <= 1'b0;
      rst_n_d <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      boot_loader_o <= next_boot;
      rst_n_d <= rst_n_s;
    end
  end

  // ==========================================================
  // bootloader request counter
  // counts synced ready low while in hold; any high sample restarts
  // it, so a short glitch on the pin never forces the bootloader
  always @(posedge sys_clk_i) begin
    if (sys_rst_i || state != `RSC_ST_HOLD || rdy_n_s) begin
      low_cnt <= {`RSC_CNT_W{1'b0}};
    end else if (!boot_req) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // ==========================================================
  // pin drive
  wire started;
  assign started = (state == `RSC_ST_APP) || (state == `RSC_ST_BOOT);

  // chip only ever pulls reset low; high comes from the pull-up
  assign reset_n_o = 1'b0;
  // drive for the hold count only, then leave the pin to its pull-up;
  // a host still holding the pin low then shows up on reset_n_i
  assign reset_n_oe_o = (state == `RSC_ST_HOLD) && !hold_done;
  assign reset_pull_up_o = 1'b1;
  assign test_pull_down_o = 1'b1;

  // ready stays released while the host may be requesting boot
  assign ready_n_o = (state == `RSC_ST_APP) ? slave_ready_i : 1'b1;
  assign ready_n_oe_o = (state == `RSC_ST_APP);
  assign ready_pull_up_o = 1'b1;

  assign irq_n_o = !(data_ready_i && started);
  assign shutdown_o = (state == `RSC_ST_OFF);
  assign core_rst_o = (state == `RSC_ST_OFF) || (state == `RSC_ST_HOLD);
  assign fw_run_o = (state == `RSC_ST_FW);
  assign serial_en_o = (state == `RSC_ST_APP);

  // io pads: pulls until startup ends, then firmware owns them
  always @(posedge sys_clk_i) begin
    if (sys_rst_i || !started) begin
      gpio_o <= {`RSC_NUM_GPIO{1'b0}};
      gpio_oe_o <= {`RSC_NUM_GPIO{1'b0}};
      gpio_pull_up_o <= {`RSC_NUM_GPIO{1'b1}};
      strap_o <= 1'b0;
      strap_oe_o <= 1'b0;
      strap_pull_up_o <= 1'b1;
    end else begin
      gpio_o <= fw_io_out_i;
      gpio_oe_o <= fw_io_drive_i;
      gpio_pull_up_o <= ~fw_io_drive_i;
      strap_o <= fw_strap_out_i;
      strap_oe_o <= fw_strap_drive_i;
      strap_pull_up_o <= ~fw_strap_drive_i;
    end
  end
endmodule

/* File: testbench/rsc_chk_sva.sv */
`timescale 1ns/1ns
// ==========================================================
// pin rule checker
module rsc_chk (
  // clock, reset and reset pin
  input wire sys_clk_i, sys_rst_i, enable_i, reset_n_i, reset_n_o, reset_n_oe_o,
  // pulls, ready and status
  input wire reset_pull_up_o, test_pull_down_o, ready_pull_up_o, ready_n_o,
  input wire ready_n_oe_o, slave_ready_i, data_ready_i, irq_n_o, shutdown_o, serial_en_o
);
  reg [15:0] hold_cnt;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // length of the chip's own reset drive
  always @(posedge sys_clk_i)
    hold_cnt <= (sys_rst_i || !reset_n_oe_o) ? 16'h0000 : hold_cnt + 16'h0001;
  a_pulls_on: assert property (
    reset_pull_up_o && test_pull_down_o && ready_pull_up_o) else $error("pull lost");
  a_shut_off: assert property (
    !enable_i [*5] |-> shutdown_o) else $error("no shutdown");
  a_rst_low: assert property (
    reset_n_oe_o |-> !reset_n_o && !reset_n_i) else $error("reset driven high");
  a_hold_max: assert property (
    reset_n_oe_o |-> hold_cnt < 16'h61A8) else $error("hold long");
  a_hold_len: assert property (
    $fell(reset_n_oe_o) && !shutdown_o |-> hold_cnt >= 16'h61A8) else $error("hold short");
  a_ready_quiet: assert property (
    !serial_en_o |-> !ready_n_oe_o) else $error("ready driven early");
  a_ready_drive: assert property (
    serial_en_o |-> ready_n_oe_o && ready_n_o == slave_ready_i) else $error("ready wrong");
  a_irq_level: assert property (
    serial_en_o |-> irq_n_o != data_ready_i) else $error("irq wrong");
  a_rst_pulse: assert property (
    $fell(reset_n_i) && serial_en_o |-> ##[2:4] reset_n_oe_o) else $error("pulse missed");
endmodule

/* File: testbench/rsc_host_model.sv */
`timescale 1ns/1ns
// ==========================================================
// host side: enable, strap, pull-downs on reset and ready
module rsc_host_model (
  // bench requests
  input wire en_req_i, rst_req_i, boot_req_i,
  // chip pad drives
  input wire dut_rst_oe_i, dut_rst_i, dut_rdy_oe_i, dut_rdy_i,
  // wired pin levels
  output wire enable_o, reset_n_o, ready_n_o, strap_o
);
  // clock runs from time zero, so enable is safe at once
  assign enable_o = en_req_i;
  // host only ever pulls low, so the chip can always win
  assign reset_n_o = !((dut_rst_oe_i && !dut_rst_i) || rst_req_i);
  // chip drive wins, else boot pull-down or pull-up
  assign ready_n_o = dut_rdy_oe_i ? dut_rdy_i : !boot_req_i;
  // strap tied high by a pull-up
  assign strap_o = 1'b1;
endmodule

/* File: testbench/rsc_startup_ctrl_tb.sv */
`timescale 1ns/1ns
// ==========================================================
// startup controller bench
module rsc_startup_ctrl_tb;
  logic sys_clk_i, sys_rst_i, fw_done_i, data_ready_i, slave_ready_i, en, rr, br;
  logic fw_strap_drive_i, fw_strap_out_i;
  logic [10:0] fw_io_drive_i, fw_io_out_i, gpio_i;
  wire enable_i, reset_n_i, ready_n_i, strap_i, reset_n_o, reset_n_oe_o, reset_pull_up_o;
  wire test_pull_down_o, ready_n_o, ready_n_oe_o, ready_pull_up_o, strap_o, strap_oe_o;
  wire strap_pull_up_o, strap_level_o, irq_n_o, shutdown_o, core_rst_o, fw_run_o;
  wire boot_loader_o, serial_en_o;
  wire [10:0] gpio_o, gpio_oe_o, gpio_pull_up_o;
  int n_errors, compares, n;
  rsc_startup_ctrl uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
    .reset_n_i(reset_n_i), .reset_n_o(reset_n_o), .reset_n_oe_o(reset_n_oe_o),
    .reset_pull_up_o(reset_pull_up_o), .test_pull_down_o(test_pull_down_o),
    .ready_n_i(ready_n_i), .ready_n_o(ready_n_o), .ready_n_oe_o(ready_n_oe_o),
    .ready_pull_up_o(ready_pull_up_o), .fw_done_i(fw_done_i), .data_ready_i(data_ready_i),
    .slave_ready_i(slave_ready_i), .fw_io_drive_i(fw_io_drive_i), .fw_io_out_i(fw_io_out_i),
    .fw_strap_drive_i(fw_strap_drive_i), .fw_strap_out_i(fw_strap_out_i), .gpio_i(gpio_i),
    .strap_i(strap_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o), .gpio_pull_up_o(gpio_pull_up_o),
    .strap_o(strap_o), .strap_oe_o(strap_oe_o), .strap_pull_up_o(strap_pull_up_o),
    .strap_level_o(strap_level_o), .irq_n_o(irq_n_o), .shutdown_o(shutdown_o),
    .core_rst_o(core_rst_o), .fw_run_o(fw_run_o), .boot_loader_o(boot_loader_o),
    .serial_en_o(serial_en_o));
  rsc_host_model host (.en_req_i(en), .rst_req_i(rr), .boot_req_i(br),
    .dut_rst_oe_i(reset_n_oe_o), .dut_rst_i(reset_n_o), .dut_rdy_oe_i(ready_n_oe_o),
    .dut_rdy_i(ready_n_o), .enable_o(enable_i), .reset_n_o(reset_n_i),
    .ready_n_o(ready_n_i), .strap_o(strap_i));
  // ==========================================================
  // clock and helpers
  initial begin
    sys_clk_i = 0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // inputs move 1 ns after the edge, never racing it
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  // bounded wait, a stuck hold ends here
  task automatic wait_fw;
    n = 0;
    while (!fw_run_o && n < 30000) begin
      step(1);
      n++;
    end
    chk(fw_run_o, 11'h001);
  endtask
  task automatic end_sim;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_pulls;
    step(2);
    chk({shutdown_o, reset_pull_up_o, test_pull_down_o, strap_pull_up_o}, 11'h00F);
    chk(gpio_pull_up_o, 11'h7FF);
    $display("pull test done");
  endtask
  task automatic t_boot;
    br = 1;
    en = 1;
    step(4);
    chk({reset_n_oe_o, reset_n_i, ready_n_oe_o}, 11'h004);
    chk({core_rst_o, fw_run_o}, 11'h002);
    wait_fw;
    chk(n + 4 >= 25001 && n + 4 <= 25006, 11'h001);
    step(2);
    chk({boot_loader_o, serial_en_o, ready_n_oe_o}, 11'h004);
    en = 0;
    step(5);
    chk({shutdown_o, irq_n_o}, 11'h003);
    br = 0;
    step(5000);
    $display("boot test done");
  endtask
  task automatic t_app;
    fw_done_i = 0;
    rr = 1;
    en = 1;
    step(25500);
    chk({fw_run_o, reset_n_oe_o, gpio_oe_o[0], gpio_pull_up_o[0]}, 11'h001);
    rr = 0;
    wait_fw;
    chk({strap_level_o, ready_n_oe_o}, 11'h002);
    step(3);
    chk({fw_run_o, serial_en_o, ready_n_oe_o, strap_level_o}, 11'h009);
    fw_done_i = 1;
    step(2);
    chk({serial_en_o, ready_n_oe_o, ready_n_i, irq_n_o}, 11'h00E);
    slave_ready_i = 0;
    data_ready_i = 0;
    fw_io_drive_i = 11'h5A5;
    fw_io_out_i = 11'h3C3;
    fw_strap_drive_i = 1;
    fw_strap_out_i = 1;
    step(2);
    chk({ready_n_i, irq_n_o, strap_oe_o, strap_o}, 11'h007);
    chk({core_rst_o, strap_pull_up_o}, 11'h000);
    chk({ready_n_i, irq_n_o}, 11'h001);
    chk(gpio_oe_o, 11'h5A5);
    chk(gpio_o, 11'h3C3);
    chk(gpio_pull_up_o, 11'h25A);
    rr = 1;
    step(2);
    rr = 0;
    step(3);
    chk({reset_n_oe_o, serial_en_o}, 11'h002);
    $display("app test done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {sys_rst_i, fw_done_i, data_ready_i, slave_ready_i} = 4'hF;
    {en, rr, br, fw_strap_drive_i, fw_strap_out_i} = 5'h00;
    {fw_io_drive_i, fw_io_out_i, gpio_i} = 33'h0;
    n_errors = 0;
    compares = 0;
    step(6);
    sys_rst_i = 0;
    t_pulls;
    t_boot;
    t_app;
    end_sim;
  end
  initial begin
    step(70000);
    n_errors++;
    end_sim;
  end
endmodule
bind rsc_startup_ctrl rsc_chk chk_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .enable_i(enable_i), .reset_n_i(reset_n_i), .reset_n_o(reset_n_o),
  .reset_n_oe_o(reset_n_oe_o), .reset_pull_up_o(reset_pull_up_o),
  .test_pull_down_o(test_pull_down_o), .ready_pull_up_o(ready_pull_up_o),
  .ready_n_o(ready_n_o), .ready_n_oe_o(ready_n_oe_o), .slave_ready_i(slave_ready_i),
  .data_ready_i(data_ready_i), .irq_n_o(irq_n_o), .shutdown_o(shutdown_o),
  .serial_en_o(serial_en_o));
